// file: dv/modulator_model.sv
// behavioural motor and modulator on the far side of the sequencer
// assumes the sequencer's clock and reset; the shaft coasts when released
`timescale 1ns/1ns
`default_nettype none
module modulator_model import seq_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire drive_cmd_t drive_cmd,
	output logic [15:0] speed_estimate,
	output logic estimate_reverse
);
	// ----------------------------------------
	// shaft speed
	// ----------------------------------------
	// follows the command in hold and ramp (running), keeps its last speed in every other phase, decel included
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_estimate <= 16'h0000;
			estimate_reverse <= 1'b0;
		end else if (drive_cmd.running) begin
			speed_estimate <= drive_cmd.freq;
			estimate_reverse <= drive_cmd.reverse;
		end
	end
endmodule
`default_nettype wire

// file: dv/motor_start_stop_sequencer_tb.sv
// self-checking bench for the start/stop sequencer over apb
// assumes the modulator model at the drive side and a short tick
`timescale 1ns/1ns
`default_nettype none
module motor_start_stop_sequencer_tb import seq_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, estimate_reverse, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] speed_estimate;
	drive_cmd_t drive_cmd;
	int mismatches = 0;
	int tests_run = 0;
	// ----------------------------------------
	// design and partner
	// ----------------------------------------
	motor_start_stop_sequencer #(.TICK_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .speed_estimate(speed_estimate),
		.estimate_reverse(estimate_reverse), .drive_cmd(drive_cmd));
	modulator_model model (.pclk(pclk), .presetn(presetn), .drive_cmd(drive_cmd),
		.speed_estimate(speed_estimate), .estimate_reverse(estimate_reverse));
	// clock, 10 ns period
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			mismatches++;
			$display("FAIL %0t no pready", $time);
			tally_and_finish();
		end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// polls status until the masked value matches, bounded
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, STATUS_OFS, 32'h0);
			n++;
		end while ((rd & m) !== v && n < 3000);
		if ((rd & m) !== v) begin
			mismatches++;
			$display("FAIL %0t status wait timed out", $time);
			tally_and_finish();
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(MODE_OFS, 32'h0);
		rdchk(SHARE_OFS, 32'h012c012c);
		rdchk(TARGET_OFS, 32'h00140000);
		apb(1'b1, 8'h28, 32'h1);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, TARGET_OFS, 32'h0);
		rdchk(TARGET_OFS, 32'h00010000);
		apb(1'b1, RATING_OFS, 32'h00c80064);
		apb(1'b1, STEP_OFS, 32'h0032000a);
		apb(1'b1, MOTOR_OFS, 32'h13881388);
		apb(1'b1, LAUNCH_OFS, 32'h000101f4);
		apb(1'b1, TARGET_OFS, 32'h006400c8);
		apb(1'b1, CTRL_OFS, 32'h1);
		repeat (3) @(posedge pclk);
		rdchk(STATUS_OFS, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, TARGET_OFS, 32'h00640258);
		apb(1'b1, CTRL_OFS, 32'h1);
		rdchk(STATUS_OFS, 32'h01f40003);
		chk({31'h0, drive_cmd.running}, 32'h1);
		wait_st(32'hffff0007, 32'h02580004);
		apb(1'b1, CTRL_OFS, 32'h0);
		rdchk(STATUS_OFS, 32'h02580005);
		wait_st(32'hffffffff, 32'h0);
		apb(1'b1, BRAKE_OFS, 32'h00010032);
		apb(1'b1, CTRL_OFS, 32'h1);
		rdchk(STATUS_OFS, 32'h00000001);
		chk({15'h0, drive_cmd.dc_inject, drive_cmd.inject_amp}, 32'h00010032);
		wait_st(32'h7, 32'h3);
		apb(1'b1, MODE_OFS, 32'h40);
		apb(1'b1, CTRL_OFS, 32'h0);
		rdchk(STATUS_OFS, 32'h0);
		chk({31'h0, drive_cmd.output_on}, 32'h0);
		apb(1'b1, MODE_OFS, 32'h45);
		apb(1'b1, CTRL_OFS, 32'h1);
		wait_st(32'h7, 32'h4);
		chk({31'h0, rd[31:16] >= 16'd400}, 32'h1);
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, MODE_OFS, 32'h40);
		apb(1'b1, BRAKE_OFS, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h3);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd & 32'h1f, 32'h14);
		chk({31'h0, drive_cmd.reverse}, 32'h1);
		wait_st(32'hffff0007, 32'h02580004);
		chk({16'h0, drive_cmd.freq}, 32'h00000258);
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, MODE_OFS, 32'h42);
		apb(1'b1, BRAKE_OFS, 32'h00010032);
		apb(1'b1, CTRL_OFS, 32'h1);
		rdchk(STATUS_OFS, 32'h00000001);
		chk({14'h0, drive_cmd.pre_excite, drive_cmd.dc_inject, drive_cmd.inject_amp},
			32'h00020032);
		wait_st(32'h1f, 32'h4);
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, MODE_OFS, 32'h50);
		apb(1'b1, BRAKE_OFS, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h1);
		wait_st(32'hffff0007, 32'h01f50004);
		wait_st(32'hffff0007, 32'h02580004);
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, MOTOR_OFS, 32'h138801f4);
		apb(1'b1, MODE_OFS, 32'h60);
		apb(1'b1, CTRL_OFS, 32'h1);
		wait_st(32'hffff0007, 32'h02090004);
		wait_st(32'hffff0007, 32'h02580004);
		// reset in mid-run returns the sequencer to idle
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(STATUS_OFS, 32'h0);
		rdchk(SHARE_OFS, 32'h012c012c);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// file: rtl/motor_start_stop_sequencer.sv
// start/stop sequencer for a motor drive output frequency, apb slave
// assumes speed_estimate comes from modulator logic on the same clock
//
// Notes on behaviour
// - start method 0 direct, 1 track, 2 pre-excite
// - direct, zero brake time: run at launch
// - direct, brake time: dc brake then launch
// - tracking finds speed, direction, starts there
// - search origin: stop freq, zero, maximum
// - search rate 1..100, default 20
// - pre-excite for its time; zero skips
// - hold launch frequency for hold time
// - launch frequency not clamped to limit
// - target below launch: stay idle, zero
// - no hold on direction switch
// - hold outside accel, inside run time
// - current percent of limited base value
// - dc brake only in direct start
// - shape 0 linear, 1 curve a, 2 curve b
// - curve a: slope rises, flat, falls
// - shares default 30%, each capped by other
// - curve b bends at rated frequency
// - curve b time grows with square ratio
// - halt method 0 decelerate, 1 coast
// - decelerate at decel rate to zero
// - coast removes output at once
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module motor_start_stop_sequencer import seq_pkg::*; #(
	parameter int unsigned TICK_CYCLES = TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] speed_estimate,
	input wire logic estimate_reverse,
	output drive_cmd_t drive_cmd
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [1:0] ctrl_q;        // bit0 run, bit1 reverse
	logic [6:0] mode_q;        // method, origin, shape, halt
	logic [31:0] launch_q;     // launch frequency, hold time
	logic [31:0] brake_q;      // brake current, brake time
	logic [9:0] head_q;        // s-curve head share
	logic [9:0] tail_q;        // s-curve tail share
	logic [15:0] target_q;     // target frequency
	logic [7:0] rate_q;        // search rate
	logic [31:0] step_q;       // accel, decel step per tick
	logic [31:0] motor_q;      // rated, maximum frequency
	logic [31:0] rating_q;     // motor, drive rated current
	logic apb_hit;             // access phase
	logic addr_ok;             // mapped address
	logic [7:0] rate_w;        // clamped rate write

	start_method_t start_method_select;
	search_origin_t search_origin_select;
	ramp_shape_t ramp_shape_select;
	logic halt_method_select;
	logic [15:0] launch_frequency;
	logic [15:0] launch_hold_time;
	logic [15:0] start_brake_time;
	logic [7:0] start_brake_current;
	logic [9:0] scurve_head_share;
	logic [9:0] scurve_tail_share;

	assign start_method_select = start_method_t'(mode_q[1:0]);
	assign search_origin_select = search_origin_t'(mode_q[3:2]);
	assign ramp_shape_select = ramp_shape_t'(mode_q[5:4]);
	assign halt_method_select = mode_q[6];
	assign launch_frequency = launch_q[15:0];
	assign launch_hold_time = launch_q[31:16];
	assign start_brake_current = brake_q[7:0];
	assign start_brake_time = brake_q[31:16];
	// each share limited to full scale minus the other
	assign scurve_head_share = (head_q > SHARE_FULL - tail_q) ? SHARE_FULL - tail_q : head_q;
	assign scurve_tail_share = (tail_q > SHARE_FULL - head_q) ? SHARE_FULL - head_q : tail_q;

	assign apb_hit = psel && penable;
	assign pready = 1'b1;
	assign addr_ok = (paddr <= STATUS_OFS) && (paddr[1:0] == 2'b00);
	assign pslverr = apb_hit && !addr_ok;
	// out-of-range rates are pulled into 1..100
	assign rate_w = (pwdata[23:16] < RATE_MIN) ? RATE_MIN :
		(pwdata[23:16] > RATE_MAX) ? RATE_MAX : pwdata[23:16];

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// apb write, one aligned word per register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 2'h0;
			mode_q <= 7'h0;
			launch_q <= 32'h0;
			brake_q <= 32'h0;
			head_q <= SHARE_RST;
			tail_q <= SHARE_RST;
			target_q <= 16'h0;
			rate_q <= RATE_RST;
			step_q <= 32'h0;
			motor_q <= 32'h0;
			rating_q <= 32'h0;
		end else if (apb_hit && pwrite) begin
			if (paddr == CTRL_OFS) begin
				ctrl_q <= pwdata[1:0];
			end else if (paddr == MODE_OFS) begin
				mode_q <= pwdata[6:0];
			end else if (paddr == LAUNCH_OFS) begin
				launch_q[15:0] <= (pwdata[15:0] > LAUNCH_MAX) ? LAUNCH_MAX : pwdata[15:0];
				launch_q[31:16] <= (pwdata[31:16] > TIME_MAX) ? TIME_MAX : pwdata[31:16];
			end else if (paddr == BRAKE_OFS) begin
				brake_q[7:0] <= (pwdata[7:0] > PCT_MAX) ? PCT_MAX : pwdata[7:0];
				brake_q[31:16] <= (pwdata[31:16] > TIME_MAX) ? TIME_MAX : pwdata[31:16];
			end else if (paddr == SHARE_OFS) begin
				head_q <= (pwdata[9:0] > SHARE_FULL) ? SHARE_FULL : pwdata[9:0];
				tail_q <= (pwdata[25:16] > SHARE_FULL) ? SHARE_FULL : pwdata[25:16];
			end else if (paddr == TARGET_OFS) begin
				target_q <= pwdata[15:0];
				rate_q <= rate_w;
			end else if (paddr == STEP_OFS) begin
				step_q <= pwdata;
			end else if (paddr == MOTOR_OFS) begin
				motor_q <= pwdata;
			end else if (paddr == RATING_OFS) begin
				rating_q <= pwdata;
			end
		end
	end

	// ----------------------------------------
	// sequencer state
	// ----------------------------------------
	seq_state_t state_q;       // phase of the start/stop sequence
	logic [15:0] freq_q;       // commanded frequency
	logic [15:0] start_f_q;    // frequency where the ramp began
	logic [15:0] stop_f_q;     // frequency at last stop
	logic dir_q;               // running direction
	logic last_dir_q;          // direction of the previous run
	logic enter_q;             // one cycle after a phase change
	logic [15:0] deci_cnt_q;   // 0.1 s units spent in the phase
	logic tick;                // control tick
	logic deci;                // 0.1 s strobe
	logic run;
	logic [15:0] origin_f;     // first search frequency
	logic [15:0] est_diff;     // search distance to estimate
	logic [15:0] base_cur;     // current base value
	logic [31:0] amp_full;     // braking or excite amplitude

	assign run = ctrl_q[0];

	// ----------------------------------------
	// time base
	// ----------------------------------------
	pulse_divider #(.DIV(TICK_CYCLES)) u_tick (
		.clk(pclk),
		.rst_n(presetn),
		.clear(1'b0),
		.step(1'b1),
		.pulse(tick)
	);

	// restarted at each phase so durations start clean
	pulse_divider #(.DIV(DECI_TICKS)) u_deci (
		.clk(pclk),
		.rst_n(presetn),
		.clear(enter_q),
		.step(tick),
		.pulse(deci)
	);

	// phase duration in 0.1 s units
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deci_cnt_q <= 16'h0;
		end else if (enter_q) begin
			deci_cnt_q <= 16'h0;
		end else if (deci) begin
			deci_cnt_q <= deci_cnt_q + 16'h1;
		end
	end

	// ----------------------------------------
	// ramp slope
	// ----------------------------------------
	logic [15:0] tgt;
	logic [15:0] stepb;
	logic [15:0] span;
	logic [15:0] prog;
	logic [31:0] frac;
	logic [31:0] slope;
	logic [47:0] slope_b;
	logic [31:0] next_f;
	logic up;

	always_comb begin
		tgt = (state_q == ST_DECEL) ? 16'h0 : target_q;
		up = tgt > freq_q;
		stepb = up ? step_q[15:0] : step_q[31:16];
		span = (tgt > start_f_q) ? tgt - start_f_q : start_f_q - tgt;
		prog = (freq_q > start_f_q) ? freq_q - start_f_q : start_f_q - freq_q;
		frac = (span == 16'h0) ? 32'd1000 : ({16'h0, prog} * 32'd1000) / {16'h0, span};
		if (frac > 32'd1000) begin
			frac = 32'd1000;
		end
		slope = {16'h0, stepb};
		slope_b = 48'h0;
		case (ramp_shape_select)
			SHAPE_A: begin
				// slope grows through the head, shrinks through the tail
				if (frac < {22'h0, scurve_head_share}) begin
					slope = ({16'h0, stepb} * (frac + 32'd1)) / {22'h0, scurve_head_share};
				end else if (frac + {22'h0, scurve_tail_share} > 32'd1000) begin
					slope = ({16'h0, stepb} * (32'd1001 - frac)) / {22'h0, scurve_tail_share};
				end
			end
			SHAPE_B: begin
				// above rated the slope falls as rated/f, so time grows with f squared
				if (motor_q[15:0] != 16'h0 && freq_q > motor_q[15:0]) begin
					slope_b = ({32'h0, stepb} * 48'd9 * {32'h0, motor_q[15:0]}) /
						({32'h0, freq_q} * 48'd8);
					slope = slope_b[31:0];
				end
			end
			default: begin
				slope = {16'h0, stepb};
			end
		endcase
		if (slope == 32'h0) begin
			slope = 32'h1;
		end
		// step toward the goal without overshoot
		if (up) begin
			next_f = ({16'h0, freq_q} + slope > {16'h0, tgt}) ? {16'h0, tgt} : {16'h0, freq_q} + slope;
		end else begin
			next_f = ({16'h0, freq_q} < {16'h0, tgt} + slope) ? {16'h0, tgt} : {16'h0, freq_q} - slope;
		end
	end

	// ----------------------------------------
	// search and current helpers
	// ----------------------------------------
	always_comb begin
		case (search_origin_select)
			ORIGIN_ZERO: origin_f = 16'h0;
			ORIGIN_MAX: origin_f = motor_q[31:16];
			default: origin_f = stop_f_q;
		endcase
		est_diff = (freq_q > speed_estimate) ? freq_q - speed_estimate : speed_estimate - freq_q;
		// base is motor current, capped at 80 % of drive current
		if ({16'h0, rating_q[15:0]} * 32'd5 <= {16'h0, rating_q[31:16]} * 32'd4) begin
			base_cur = rating_q[15:0];
		end else begin
			base_cur = 16'(({16'h0, rating_q[31:16]} * 32'd4) / 32'd5);
		end
		amp_full = ({16'h0, base_cur} * {24'h0, start_brake_current}) / 32'd100;
	end

	// ----------------------------------------
	// sequence state machine
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			freq_q <= 16'h0;
			start_f_q <= 16'h0;
			stop_f_q <= 16'h0;
			dir_q <= 1'b0;
			last_dir_q <= 1'b0;
			enter_q <= 1'b0;
		end else begin
			enter_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					freq_q <= 16'h0;
					// a target under launch leaves the drive in standby
					if (run && target_q >= launch_frequency) begin
						enter_q <= 1'b1;
						dir_q <= ctrl_q[1];
						if (start_method_select == START_TRACK) begin
							state_q <= ST_SEARCH;
							freq_q <= origin_f;
						end else if (start_method_select == START_DIRECT
							&& start_brake_time != 16'h0) begin
							state_q <= ST_BRAKE;
						end else if (start_method_select == START_PREEXC
							&& start_brake_time != 16'h0) begin
							state_q <= ST_BRAKE;
						end else if (ctrl_q[1] != last_dir_q) begin
							state_q <= ST_RAMP;
							freq_q <= launch_frequency;
							start_f_q <= launch_frequency;
						end else begin
							state_q <= ST_HOLD;
							freq_q <= launch_frequency;
						end
					end
				end
				ST_BRAKE: begin
					if (!run) begin
						state_q <= ST_IDLE;
						enter_q <= 1'b1;
					// the count still shows the last phase on the entry cycle
					end else if (!enter_q && deci_cnt_q >= start_brake_time) begin
						enter_q <= 1'b1;
						freq_q <= launch_frequency;
						start_f_q <= launch_frequency;
						state_q <= (dir_q != last_dir_q) ? ST_RAMP : ST_HOLD;
					end
				end
				ST_SEARCH: begin
					if (!run) begin
						state_q <= ST_IDLE;
						freq_q <= 16'h0;
						enter_q <= 1'b1;
					end else if (tick) begin
						if (est_diff <= {8'h0, rate_q}) begin
							// locked: continue from the tracked speed, no hold
							freq_q <= speed_estimate;
							start_f_q <= speed_estimate;
							dir_q <= estimate_reverse;
							state_q <= ST_RAMP;
							enter_q <= 1'b1;
						end else if (freq_q > speed_estimate) begin
							freq_q <= freq_q - {8'h0, rate_q};
						end else begin
							freq_q <= freq_q + {8'h0, rate_q};
						end
					end
				end
				ST_HOLD: begin
					if (!run) begin
						state_q <= halt_method_select ? ST_IDLE : ST_DECEL;
						// a coast stop drops the frequency together with the output
						freq_q <= halt_method_select ? 16'h0 : freq_q;
						start_f_q <= freq_q;
						stop_f_q <= freq_q;
						last_dir_q <= dir_q;
						enter_q <= 1'b1;
					end else if (!enter_q && deci_cnt_q >= launch_hold_time) begin
						// ramp timing starts only after the hold
						state_q <= ST_RAMP;
						start_f_q <= freq_q;
						enter_q <= 1'b1;
					end
				end
				ST_RAMP: begin
					if (!run) begin
						stop_f_q <= freq_q;
						start_f_q <= freq_q;
						last_dir_q <= dir_q;
						enter_q <= 1'b1;
						if (halt_method_select) begin
							state_q <= ST_IDLE;
							freq_q <= 16'h0;
						end else begin
							state_q <= ST_DECEL;
						end
					end else if (tick) begin
						freq_q <= next_f[15:0];
						if (next_f[15:0] == target_q) begin
							start_f_q <= target_q;
						end
					end
				end
				ST_DECEL: begin
					if (freq_q == 16'h0) begin
						state_q <= ST_IDLE;
						enter_q <= 1'b1;
					end else if (tick) begin
						freq_q <= next_f[15:0];
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign drive_cmd.freq = freq_q;
	assign drive_cmd.reverse = dir_q;
	assign drive_cmd.output_on = (state_q != ST_IDLE);
	assign drive_cmd.dc_inject = (state_q == ST_BRAKE)
		&& (start_method_select == START_DIRECT);
	assign drive_cmd.pre_excite = (state_q == ST_BRAKE)
		&& (start_method_select == START_PREEXC);
	assign drive_cmd.inject_amp = (state_q == ST_BRAKE) ? amp_full[15:0] : 16'h0;
	// hold counts as run time for a step program
	assign drive_cmd.running = (state_q == ST_HOLD) || (state_q == ST_RAMP);

	// read mux, zero on unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == CTRL_OFS) begin
				prdata <= {30'h0, ctrl_q};
			end else if (paddr == MODE_OFS) begin
				prdata <= {25'h0, mode_q};
			end else if (paddr == LAUNCH_OFS) begin
				prdata <= launch_q;
			end else if (paddr == BRAKE_OFS) begin
				prdata <= brake_q;
			end else if (paddr == SHARE_OFS) begin
				prdata <= {6'h0, tail_q, 6'h0, head_q};
			end else if (paddr == TARGET_OFS) begin
				prdata <= {8'h0, rate_q, target_q};
			end else if (paddr == STEP_OFS) begin
				prdata <= step_q;
			end else if (paddr == MOTOR_OFS) begin
				prdata <= motor_q;
			end else if (paddr == RATING_OFS) begin
				prdata <= rating_q;
			end else if (paddr == STATUS_OFS) begin
				prdata <= {freq_q, 11'h0, dir_q, 1'b0, state_q};
			end else begin
				prdata <= 32'h0;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	standby_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_IDLE && run && target_q < launch_frequency
		|=> state_q == ST_IDLE && freq_q == 16'h0)
		else $error("started with target below launch frequency");
	direct_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_IDLE && run && target_q >= launch_frequency
		&& start_method_select == START_DIRECT && start_brake_time == 16'h0
		|=> (state_q == ST_HOLD || state_q == ST_RAMP) && freq_q == $past(launch_frequency))
		else $error("direct start missed launch frequency");
	brake_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_IDLE && run && target_q >= launch_frequency
		&& start_method_select == START_DIRECT && start_brake_time != 16'h0
		|=> drive_cmd.dc_inject && !drive_cmd.pre_excite)
		else $error("direct start skipped dc braking");
	coast_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_RAMP || state_q == ST_HOLD) && !run && halt_method_select
		|=> !drive_cmd.output_on && freq_q == 16'h0)
		else $error("coast stop left output on");
	decel_down_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_DECEL ##1 state_q == ST_DECEL |-> freq_q <= $past(freq_q))
		else $error("frequency rose while decelerating");
	hold_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_HOLD |-> freq_q == launch_frequency && drive_cmd.running)
		else $error("hold phase off launch frequency");
	rate_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		rate_q >= RATE_MIN && rate_q <= RATE_MAX)
		else $error("search rate out of range");
	share_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
		{1'b0, scurve_head_share} + {1'b0, scurve_tail_share} <= {1'b0, SHARE_FULL})
		else $error("s-curve shares exceed full scale");
	tick_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_RAMP && run && !tick |=> freq_q == $past(freq_q))
		else $error("ramp moved between ticks");

endmodule
`default_nettype wire

// file: rtl/pulse_divider.sv
// counts enable strobes and emits one pulse every DIV of them
// assumes a single clock domain; clear restarts the count
`timescale 1ns/1ns
`default_nettype none
module pulse_divider #(
	parameter int unsigned DIV = 100
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic step,
	output logic pulse
);

	logic [31:0] cnt_q; // strobes seen so far

	// last strobe of a period fires the pulse
	assign pulse = step && (cnt_q == 32'(DIV - 1));

	// wrap counter, restarted by clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
		end else if (clear || pulse) begin
			cnt_q <= 32'h0;
		end else if (step) begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

endmodule
`default_nettype wire

// file: rtl/seq_pkg.sv
// constants, encodings and carriers for the motor start/stop sequencer
// assumes a 100 MHz control clock and frequencies in 0.01 Hz units
package seq_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;      // control clock rate
	localparam int unsigned TICK_US = 1000;            // control tick period, us
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US; // cycles per tick
	localparam int unsigned DECI_MS = 100;             // duration unit, 0.1 s in ms
	localparam int unsigned DECI_TICKS = DECI_MS * 1000 / TICK_US; // ticks per unit

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;   // run, reverse
	localparam logic [7:0] MODE_OFS = 8'h04;   // method, origin, shape, halt
	localparam logic [7:0] LAUNCH_OFS = 8'h08; // launch frequency, hold time
	localparam logic [7:0] BRAKE_OFS = 8'h0c;  // brake current, brake time
	localparam logic [7:0] SHARE_OFS = 8'h10;  // s-curve head and tail shares
	localparam logic [7:0] TARGET_OFS = 8'h14; // target frequency, search rate
	localparam logic [7:0] STEP_OFS = 8'h18;   // accel and decel step per tick
	localparam logic [7:0] MOTOR_OFS = 8'h1c;  // rated and maximum frequency
	localparam logic [7:0] RATING_OFS = 8'h20; // motor and drive rated current
	localparam logic [7:0] STATUS_OFS = 8'h24; // read-only state and frequency

	// ----------------------------------------
	// reset values and limits
	// ----------------------------------------
	localparam logic [9:0] SHARE_RST = 10'h12c;  // 30.0 %
	localparam logic [9:0] SHARE_FULL = 10'h3e8; // 100.0 %
	localparam logic [7:0] RATE_RST = 8'h14;     // 20
	localparam logic [7:0] RATE_MIN = 8'h01;
	localparam logic [7:0] RATE_MAX = 8'h64;     // 100
	localparam logic [15:0] LAUNCH_MAX = 16'h03e8; // 10.00 Hz
	localparam logic [15:0] TIME_MAX = 16'h03e8;   // 100.0 s
	localparam logic [7:0] PCT_MAX = 8'h64;        // 100 %

	// ----------------------------------------
	// encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		START_DIRECT = 2'b00,
		START_TRACK = 2'b01,
		START_PREEXC = 2'b10
	} start_method_t;

	typedef enum logic [1:0] {
		ORIGIN_STOP = 2'b00,
		ORIGIN_ZERO = 2'b01,
		ORIGIN_MAX = 2'b10
	} search_origin_t;

	typedef enum logic [1:0] {
		SHAPE_LINEAR = 2'b00,
		SHAPE_A = 2'b01,
		SHAPE_B = 2'b10
	} ramp_shape_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_BRAKE = 3'b001,
		ST_SEARCH = 3'b010,
		ST_HOLD = 3'b011,
		ST_RAMP = 3'b100,
		ST_DECEL = 3'b101
	} seq_state_t;

	// command to the modulator
	typedef struct packed {
		logic [15:0] freq;         // output frequency, 0.01 Hz
		logic reverse;             // rotation direction
		logic output_on;           // modulator enabled
		logic dc_inject;           // start dc braking active
		logic pre_excite;          // field build active
		logic [15:0] inject_amp;   // braking or excite current, rated-current units
		logic running;             // hold or ramp, counts as run time
	} drive_cmd_t;

endpackage
